//--- pkg/vci_pkg.sv
// Purpose: Constants for the vertical-blanking caption and copy-management inserter.
// Assumes: 10-bit video samples at the encoder pixel rate; AXI4-Lite register access.
// Notes:   Functional notes below, one line each.
package vci_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CC0    = 8'h04;
  localparam logic [7:0] OFS_CC1    = 8'h08;
  localparam logic [7:0] OFS_CCX0   = 8'h0C;
  localparam logic [7:0] OFS_CCX1   = 8'h10;
  localparam logic [7:0] OFS_CGMS0  = 8'h14;
  localparam logic [7:0] OFS_CGMS1  = 8'h18;
  localparam logic [7:0] OFS_CGMS2  = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // CTRL fields and reset value.
  localparam int         CTRL_CC_LINE21_BIT  = 0;
  localparam int         CTRL_CC_LINE284_BIT = 1;
  localparam int         CTRL_NTSC_BIT       = 2;
  localparam logic [7:0] CTRL_RESET          = 8'h04;
  // CGMS0 fields.
  localparam int         CGMS_CRC_AUTO_BIT = 4;
  localparam int         CGMS_ODD_EN_BIT   = 5;
  localparam int         CGMS_EVEN_EN_BIT  = 6;
  localparam logic [7:0] DATA_RESET        = 8'h00;
  // Line numbers.
  localparam logic [9:0] LINE_CC_ODD    = 10'h015;
  localparam logic [9:0] LINE_CC_EVEN   = 10'h11C;
  localparam logic [9:0] LINE_CGMS_ODD  = 10'h014;
  localparam logic [9:0] LINE_CGMS_EVEN = 10'h11B;
  // Waveform timing in pixel samples.
  localparam logic [9:0] CC_LEAD_SAMPLES   = 10'h118;
  localparam logic [9:0] CGMS_LEAD_SAMPLES = 10'h0F0;
  localparam logic [9:0] CC_BIT_SAMPLES    = 10'h036;
  localparam logic [9:0] CGMS_BIT_SAMPLES  = 10'h03C;
  localparam logic [4:0] CC_RUNIN_BITS     = 5'h07;
  localparam logic [4:0] CC_GAP_BITS       = 5'h02;
  localparam logic [4:0] CC_DATA_BITS      = 5'h10;
  localparam logic [4:0] CGMS_DATA_BITS    = 5'h14;
  localparam logic [4:0] SINE_STEPS        = 5'h10;
  // Output levels.
  localparam logic [9:0] LVL_BLANK = 10'h100;
  localparam logic [9:0] LVL_CC_HI = 10'h230;
  localparam logic [9:0] LVL_CG_HI = 10'h2C0;
  localparam logic [5:0] CRC_PRESET = 6'h3F;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_RUNIN = 3'b010,
    ST_GAP   = 3'b011,
    ST_START = 3'b100,
    ST_DATA  = 3'b101
  } vci_state_t;
endpackage

//--- src/vci_inserter.sv
// Purpose: Inserts caption and copy-management waveforms into the pixel stream.
// Assumes: Line timing inputs come from encoder logic on the same clock.
// Notes:   Output passes through an 8-word FIFO so the sink can stall the source.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module vci_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,     // Clock.
  input  wire logic             rst_i,     // Async reset, active high.
  input  wire logic [WIDTH-1:0] in_data_i, // Write data.
  input  wire logic             in_valid_i,// Write request.
  output logic                  in_ready_o,// Space available.
  output logic [WIDTH-1:0]      out_data_o,// Head word.
  output logic                  out_valid_o,// Head valid.
  input  wire logic             out_ready_i // Head taken.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wptr_reg - rptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wptr_reg != rptr_reg;
  assign out_data_o  = mem[rptr_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop) rptr_reg <= rptr_reg + 1'b1;
    end
  end
endmodule // vci_fifo

////////////////////////////////////////////////////////////////////////////////

module vci_inserter (
  input  wire logic        MCLK_I,        // 200 MHz clock.
  input  wire logic        SYS_RST_I,     // Async reset, active high.
  input  wire logic [31:0] S_AXI_AWADDR,  // Write address.
  input  wire logic        S_AXI_AWVALID, // Write address valid.
  output logic             S_AXI_AWREADY, // Write address ready.
  input  wire logic [31:0] S_AXI_WDATA,   // Write data.
  input  wire logic [3:0]  S_AXI_WSTRB,   // Write strobes.
  input  wire logic        S_AXI_WVALID,  // Write data valid.
  output logic             S_AXI_WREADY,  // Write data ready.
  output logic [1:0]       S_AXI_BRESP,   // Write response.
  output logic             S_AXI_BVALID,  // Write response valid.
  input  wire logic        S_AXI_BREADY,  // Write response ready.
  input  wire logic [31:0] S_AXI_ARADDR,  // Read address.
  input  wire logic        S_AXI_ARVALID, // Read address valid.
  output logic             S_AXI_ARREADY, // Read address ready.
  output logic [31:0]      S_AXI_RDATA,   // Read data.
  output logic [1:0]       S_AXI_RRESP,   // Read response.
  output logic             S_AXI_RVALID,  // Read data valid.
  input  wire logic        S_AXI_RREADY,  // Read data ready.
  input  wire logic        LINE_START_I,  // One-cycle pulse at line start.
  input  wire logic [9:0]  LINE_NUM_I,    // Line number of the new line.
  input  wire logic        FIELD_ODD_I,   // High in odd fields.
  input  wire logic [9:0]  PIX_DATA_I,    // Incoming pixel sample.
  input  wire logic        PIX_VALID_I,   // Pixel sample valid.
  output logic             PIX_READY_O,   // Pixel sample accepted.
  output logic [9:0]       VID_DATA_O,    // Outgoing sample.
  output logic             VID_VALID_O,   // Outgoing sample valid.
  input  wire logic        VID_READY_I,   // Sink ready.
  output logic             VBI_ACTIVE_O   // High while inserting.
);
  import vci_pkg::*;

  function automatic logic [7:0] add_parity(input logic [7:0] b);
    add_parity = {~(^b[6:0]), b[6:0]};
  endfunction

  function automatic logic [5:0] cgms_crc(input logic [13:0] d);
    logic [5:0] c;
    logic       fb;
    c = CRC_PRESET;
    for (int i = 0; i < 14; i++) begin
      fb = d[i] ^ c[5];
      c  = {c[4:0], fb} ^ {4'h0, fb, 1'b0};
    end
    cgms_crc = c;
  endfunction

  function automatic logic [9:0] sine_lvl(input logic [3:0] idx);
    case (idx)
      4'h0: sine_lvl = 10'h198;
      4'h1: sine_lvl = 10'h1D2;
      4'h2: sine_lvl = 10'h203;
      4'h3: sine_lvl = 10'h224;
      4'h4: sine_lvl = 10'h230;
      4'h5: sine_lvl = 10'h224;
      4'h6: sine_lvl = 10'h203;
      4'h7: sine_lvl = 10'h1D2;
      4'h8: sine_lvl = 10'h198;
      4'h9: sine_lvl = 10'h15E;
      4'hA: sine_lvl = 10'h12D;
      4'hB: sine_lvl = 10'h10C;
      4'hC: sine_lvl = 10'h100;
      4'hD: sine_lvl = 10'h10C;
      4'hE: sine_lvl = 10'h12D;
      default: sine_lvl = 10'h15E;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register file over AXI4-Lite.

  logic [7:0]  ctrl_reg, cc0_reg, cc1_reg, ccx0_reg, ccx1_reg;
  logic [7:0]  cgms0_reg, cgms1_reg, cgms2_reg;
  logic [7:0]  cc_sent_reg, cgms_sent_reg;
  logic        aw_full_reg, w_full_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic        ar_take;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_full_reg && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign do_write      = aw_full_reg && w_full_reg && !S_AXI_BVALID;
  assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR[7:0];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr_reg <= OFS_CGMS2 && aw_addr_reg[1:0] == 2'h0) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register bits; the upper lanes read as zero except in STATUS.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_reg  <= CTRL_RESET;
      cc0_reg   <= DATA_RESET;
      cc1_reg   <= DATA_RESET;
      ccx0_reg  <= DATA_RESET;
      ccx1_reg  <= DATA_RESET;
      cgms0_reg <= DATA_RESET;
      cgms1_reg <= DATA_RESET;
      cgms2_reg <= DATA_RESET;
    end else if (do_write && w_strb_reg[0]) begin
      case (aw_addr_reg)
        OFS_CTRL:  ctrl_reg  <= w_data_reg[7:0];
        OFS_CC0:   cc0_reg   <= w_data_reg[7:0];
        OFS_CC1:   cc1_reg   <= w_data_reg[7:0];
        OFS_CCX0:  ccx0_reg  <= w_data_reg[7:0];
        OFS_CCX1:  ccx1_reg  <= w_data_reg[7:0];
        OFS_CGMS0: cgms0_reg <= w_data_reg[7:0];
        OFS_CGMS1: cgms1_reg <= w_data_reg[7:0];
        OFS_CGMS2: cgms2_reg <= w_data_reg[7:0];
        default:   ;
      endcase
    end
  end

  vci_state_t state_reg, state_next;
  logic       kind_cgms_reg;
  logic       field_odd_reg;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (S_AXI_ARADDR[7:0])
      OFS_CTRL:   rd_word[7:0] = ctrl_reg;
      OFS_CC0:    rd_word[7:0] = cc0_reg;
      OFS_CC1:    rd_word[7:0] = cc1_reg;
      OFS_CCX0:   rd_word[7:0] = ccx0_reg;
      OFS_CCX1:   rd_word[7:0] = ccx1_reg;
      OFS_CGMS0:  rd_word[7:0] = cgms0_reg;
      OFS_CGMS1:  rd_word[7:0] = cgms1_reg;
      OFS_CGMS2:  rd_word[7:0] = cgms2_reg;
      OFS_STATUS: rd_word = {8'h00, cgms_sent_reg, cc_sent_reg, 3'h0,
                             field_odd_reg, kind_cgms_reg, state_reg};
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (ar_take) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line selection and snapshot of the data to send.

  logic        cc_odd_hit, cc_even_hit, cgms_hit, line_go;
  logic [19:0] cgms_word;
  logic [19:0] shift_reg;
  logic [9:0]  cnt_reg;
  logic [4:0]  bit_reg;
  logic [5:0]  acc_reg;
  logic        cc_line_reg;
  logic [3:0]  sine_idx_reg;
  logic        in_take;
  logic        fifo_ready;
  logic        active;
  logic [9:0]  gen_lvl;
  logic [9:0]  bit_len;
  logic        bit_end;

  assign cc_odd_hit  = FIELD_ODD_I && LINE_NUM_I == LINE_CC_ODD &&
                       ctrl_reg[CTRL_CC_LINE21_BIT];
  assign cc_even_hit = !FIELD_ODD_I && LINE_NUM_I == LINE_CC_EVEN &&
                       ctrl_reg[CTRL_CC_LINE284_BIT];
  assign cgms_hit    = ctrl_reg[CTRL_NTSC_BIT] &&
                       ((FIELD_ODD_I && LINE_NUM_I == LINE_CGMS_ODD &&
                         cgms0_reg[CGMS_ODD_EN_BIT]) ||
                        (!FIELD_ODD_I && LINE_NUM_I == LINE_CGMS_EVEN &&
                         cgms0_reg[CGMS_EVEN_EN_BIT]));
  assign line_go     = LINE_START_I && (cc_odd_hit || cc_even_hit || cgms_hit);

  // Word is sent C0 first; bit i of the word is Ci.
  assign cgms_word = cgms0_reg[CGMS_CRC_AUTO_BIT] ?
                     {cgms_crc({cgms1_reg[5:0], cgms2_reg}), cgms1_reg[5:0], cgms2_reg} :
                     {cgms0_reg[3:0], cgms1_reg, cgms2_reg};

  // The data registers are the only buffer, sampled at the start of the line,
  // so a byte loaded on the line before goes out in the same field.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      shift_reg     <= 20'h00000;
      kind_cgms_reg <= 1'b0;
      field_odd_reg <= 1'b0;
    end else if (line_go) begin
      field_odd_reg <= FIELD_ODD_I;
      kind_cgms_reg <= cgms_hit;
      if (cgms_hit) begin
        shift_reg <= cgms_word;
      end else if (cc_odd_hit) begin
        shift_reg <= {4'h0, add_parity(cc1_reg), add_parity(cc0_reg)};
      end else begin
        shift_reg <= {4'h0, add_parity(ccx1_reg), add_parity(ccx0_reg)};
      end
    end else if (state_reg == ST_DATA && bit_end) begin
      shift_reg <= {1'b0, shift_reg[19:1]};
    end
  end

  // A caption line is blanked from its start to the next line start, so no pixel leaks.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cc_line_reg <= 1'b0;
    end else if (LINE_START_I) begin
      cc_line_reg <= (cc_odd_hit || cc_even_hit) && !cgms_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Waveform sequencer, stepped by each pixel sample taken.

  assign active   = state_reg != ST_IDLE && state_reg != ST_LEAD;
  assign in_take  = PIX_VALID_I && fifo_ready;
  assign bit_len  = state_reg == ST_LEAD ?
                    (kind_cgms_reg ? CGMS_LEAD_SAMPLES : CC_LEAD_SAMPLES) :
                    (kind_cgms_reg ? CGMS_BIT_SAMPLES : CC_BIT_SAMPLES);
  assign bit_end  = in_take && cnt_reg == bit_len - 10'h001;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  state_next = state_reg;
      ST_LEAD:  if (bit_end) state_next = kind_cgms_reg ? ST_START : ST_RUNIN;
      ST_RUNIN: if (bit_end && bit_reg == CC_RUNIN_BITS - 5'h01) state_next = ST_GAP;
      ST_GAP:   if (bit_end && bit_reg == CC_GAP_BITS - 5'h01) state_next = ST_START;
      ST_START: if (bit_end) state_next = ST_DATA;
      ST_DATA: begin
        if (bit_end && bit_reg == (kind_cgms_reg ? CGMS_DATA_BITS : CC_DATA_BITS) - 5'h01) begin
          state_next = ST_IDLE;
        end
      end
      default:  state_next = ST_IDLE;
    endcase
    if (line_go) state_next = ST_LEAD;
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 10'h000;
      bit_reg   <= 5'h00;
    end else begin
      state_reg <= state_next;
      if (line_go || state_next != state_reg) begin
        cnt_reg <= 10'h000;
        bit_reg <= 5'h00;
      end else if (bit_end) begin
        cnt_reg <= 10'h000;
        bit_reg <= bit_reg + 5'h01;
      end else if (in_take) begin
        cnt_reg <= cnt_reg + 10'h001;
      end
    end
  end

  // Run-in phase steps sixteen table entries per bit, so it stays locked.
  // The phase sum reaches one bit length less one, so it needs six bits.
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      acc_reg      <= 6'h00;
      sine_idx_reg <= 4'h0;
    end else if (state_reg != ST_RUNIN) begin
      acc_reg      <= 6'h00;
      sine_idx_reg <= 4'h0;
    end else if (in_take) begin
      if (bit_end) begin
        acc_reg      <= 6'h00;
        sine_idx_reg <= 4'h0;
      end else if ({4'h0, acc_reg} + {5'h00, SINE_STEPS} >= CC_BIT_SAMPLES) begin
        acc_reg      <= 6'((10'(acc_reg) + 10'(SINE_STEPS)) - CC_BIT_SAMPLES);
        sine_idx_reg <= sine_idx_reg + 4'h1;
      end else begin
        acc_reg <= acc_reg + {1'b0, SINE_STEPS};
      end
    end
  end

  always_comb begin
    case (state_reg)
      ST_RUNIN: gen_lvl = sine_lvl(sine_idx_reg);
      ST_START: gen_lvl = kind_cgms_reg ? LVL_CG_HI : LVL_CC_HI;
      ST_DATA:  gen_lvl = !shift_reg[0] ? LVL_BLANK : (kind_cgms_reg ? LVL_CG_HI : LVL_CC_HI);
      default:  gen_lvl = LVL_BLANK;
    endcase
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cc_sent_reg   <= 8'h00;
      cgms_sent_reg <= 8'h00;
      VBI_ACTIVE_O  <= 1'b0;
    end else begin
      VBI_ACTIVE_O <= active;
      if (state_reg == ST_DATA && state_next == ST_IDLE) begin
        if (kind_cgms_reg) cgms_sent_reg <= cgms_sent_reg + 8'h01;
        else cc_sent_reg <= cc_sent_reg + 8'h01;
      end
    end
  end

  assign PIX_READY_O = fifo_ready;

  // While inserting, incoming pixels are taken and replaced by the waveform.
  vci_fifo #(.WIDTH(10), .DEPTH(8)) u_fifo (
    .clk_i       (MCLK_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   ((active || cc_line_reg) ? gen_lvl : PIX_DATA_I),
    .in_valid_i  (PIX_VALID_I),
    .in_ready_o  (fifo_ready),
    .out_data_o  (VID_DATA_O),
    .out_valid_o (VID_VALID_O),
    .out_ready_i (VID_READY_I)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_runin_end;
    state_reg == ST_RUNIN && bit_end && bit_reg == CC_RUNIN_BITS - 5'h01;
  endsequence

  chk_cc_line_start: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    LINE_START_I && (cc_odd_hit || cc_even_hit) && !cgms_hit |=>
      state_reg == ST_LEAD && !kind_cgms_reg)
    else $error("caption line did not start sequencer");
  chk_runin_gap: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_runin_end and !LINE_START_I |=> state_reg == ST_GAP && bit_reg == 5'h00)
    else $error("run-in not followed by blank gap");
  chk_start_level: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    state_reg == ST_START |-> gen_lvl == (kind_cgms_reg ? LVL_CG_HI : LVL_CC_HI))
    else $error("start or reference pulse not high");
  chk_odd_parity: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    line_go && !cgms_hit |=> ^shift_reg[7:0] && ^shift_reg[15:8])
    else $error("caption byte without odd parity");
  chk_ext_source: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    line_go && cc_even_hit && !cgms_hit |=> shift_reg[6:0] == $past(ccx0_reg[6:0]))
    else $error("line 284 not taken from extended registers");
  chk_pixel_drop: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (active || cc_line_reg) && in_take |-> u_fifo.in_data_i == gen_lvl)
    else $error("pixel data leaked into inserted line");
  chk_cgms_ntsc: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    LINE_START_I && !ctrl_reg[CTRL_NTSC_BIT] |=> !kind_cgms_reg || state_reg != ST_LEAD)
    else $error("copy data started outside NTSC");
  chk_cgms_raw: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    line_go && cgms_hit && !cgms0_reg[CGMS_CRC_AUTO_BIT] |=>
      shift_reg == {$past(cgms0_reg[3:0]), $past(cgms1_reg), $past(cgms2_reg)})
    else $error("copy word altered without auto CRC");
  chk_crc_zero: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    line_go && cgms_hit && cgms0_reg[CGMS_CRC_AUTO_BIT] && cgms1_reg[5:0] == 6'h00 &&
      cgms2_reg == 8'h00 |=> shift_reg[19:14] == 6'h18 && shift_reg[13:0] == 14'h0)
    else $error("auto CRC word wrong for zero data");
endmodule // vci_inserter

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the caption and copy-management inserter.
// Assumes: Output sample n is the waveform of input take n, since the FIFO keeps order.
// Notes:   Only mid-bit samples are compared, so edge shaping cannot cause false alarms.
`timescale 1ns/1ps
module tb_top;
  import vci_pkg::*;
  typedef struct {int idx; logic [9:0] v;} vci_note_t;
  logic        MCLK_I = 1'b0, SYS_RST_I = 1'b1, stall = 1'b1, seen_act = 1'b0;
  logic [31:0] S_AXI_AWADDR = '0, S_AXI_WDATA = '0, S_AXI_ARADDR = '0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, VID_VALID_O, VID_READY_I;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        LINE_START_I = 0, FIELD_ODD_I = 0, PIX_VALID_I = 0, PIX_READY_O, VBI_ACTIVE_O;
  logic [9:0]  LINE_NUM_I = '0, PIX_DATA_I = '0, VID_DATA_O;
  logic [31:0] seed = 32'd44686, prnd = 32'd44686;
  int          n_errors = 0, cmp_count = 0, in_count = 0, out_count = 0, base = 0;
  vci_note_t   q[$];
  always #2.5 MCLK_I = ~MCLK_I;
  vci_inserter uut (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .LINE_START_I(LINE_START_I), .LINE_NUM_I(LINE_NUM_I),
    .FIELD_ODD_I(FIELD_ODD_I), .PIX_DATA_I(PIX_DATA_I), .PIX_VALID_I(PIX_VALID_I),
    .PIX_READY_O(PIX_READY_O), .VID_DATA_O(VID_DATA_O), .VID_VALID_O(VID_VALID_O),
    .VID_READY_I(VID_READY_I), .VBI_ACTIVE_O(VBI_ACTIVE_O));
  vci_sink u_sink (.clk_i(MCLK_I), .rst_i(SYS_RST_I), .stall_i(stall), .ready_o(VID_READY_I));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    S_AXI_AWADDR  <= {24'h0, a};
    S_AXI_WDATA   <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    fork
      begin
        @(posedge MCLK_I iff S_AXI_AWREADY);
        S_AXI_AWVALID <= 1'b0;
      end
      begin
        @(posedge MCLK_I iff S_AXI_WREADY);
        S_AXI_WVALID <= 1'b0;
      end
    join
    S_AXI_BREADY <= 1'b1;
    @(posedge MCLK_I iff S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    chk({30'h0, S_AXI_BRESP}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    S_AXI_ARADDR  <= {24'h0, a};
    S_AXI_ARVALID <= 1'b1;
    @(posedge MCLK_I iff S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    S_AXI_RREADY  <= 1'b1;
    @(posedge MCLK_I iff S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, ed);
    chk({30'h0, S_AXI_RRESP}, {30'h0, er});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Pixel data changes only on a take, so a stalled sample is held as the handshake needs.
  always @(posedge MCLK_I) begin
    if (PIX_VALID_I && PIX_READY_O) begin
      in_count   <= in_count + 1;
      PIX_DATA_I <= prnd[9:0];
      prnd       <= xs(prnd);
    end
    if (VID_VALID_O && VID_READY_I) begin
      if (q.size() > 0 && q[0].idx == out_count) begin
        chk({22'h0, VID_DATA_O}, {22'h0, q[0].v});
        void'(q.pop_front());
      end
      out_count <= out_count + 1;
    end
    if (LINE_START_I) seen_act <= 1'b0;
    else if (VBI_ACTIVE_O) seen_act <= 1'b1;
  end
  task automatic note(input int off, input logic [9:0] v);
    q.push_back('{base + off, v});
  endtask
  task automatic run_line(input logic [9:0] ln, input logic odd);
    PIX_VALID_I  <= 1'b0;
    LINE_NUM_I   <= ln;
    FIELD_ODD_I  <= odd;
    @(posedge MCLK_I);
    LINE_START_I <= 1'b1;
    @(posedge MCLK_I);
    LINE_START_I <= 1'b0;
    PIX_VALID_I  <= 1'b1;
    base = in_count;
  endtask
  task automatic finish_line();
    while (out_count < base + 1800) @(posedge MCLK_I);
    chk(q.size(), 0);
  endtask
  task automatic cap_line(input logic [9:0] ln, input logic odd, input logic [7:0] a0, a1,
                          input logic [7:0] b0, b1);
    int o;
    logic [15:0] bits;
    bits = {~^b1[6:0], b1[6:0], ~^b0[6:0], b0[6:0]};
    wr(a0, {24'h0, b0}, RESP_OKAY);
    wr(a1, {24'h0, b1}, RESP_OKAY);
    run_line(ln, odd);
    o = CC_LEAD_SAMPLES + CC_RUNIN_BITS * CC_BIT_SAMPLES + CC_BIT_SAMPLES / 2;
    note(o, LVL_BLANK);
    o = o + CC_GAP_BITS * CC_BIT_SAMPLES;
    note(o, LVL_CC_HI);
    for (int k = 0; k < 16; k++) note(o + (k + 1) * CC_BIT_SAMPLES, bits[k] ? LVL_CC_HI : LVL_BLANK);
    finish_line();
    chk({31'h0, seen_act}, 32'h1);
  endtask
  task automatic cg_line(input logic [9:0] ln, input logic odd, input logic [7:0] r0, r1, r2);
    logic [19:0] w;
    logic [5:0] c;
    int o;
    w = {r0[3:0], r1, r2};
    c = CRC_PRESET;
    for (int k = 0; k < 14; k++) c = {c[4:1], c[0] ^ w[k] ^ c[5], w[k] ^ c[5]};
    if (r0[CGMS_CRC_AUTO_BIT]) w[19:14] = c;
    wr(OFS_CGMS0, {24'h0, r0}, RESP_OKAY);
    wr(OFS_CGMS1, {24'h0, r1}, RESP_OKAY);
    wr(OFS_CGMS2, {24'h0, r2}, RESP_OKAY);
    run_line(ln, odd);
    o = CGMS_LEAD_SAMPLES + CGMS_BIT_SAMPLES / 2;
    note(o, LVL_CG_HI);
    for (int k = 0; k < 20; k++) note(o + (k + 1) * CGMS_BIT_SAMPLES, w[k] ? LVL_CG_HI : LVL_BLANK);
    finish_line();
  endtask
  task automatic quiet(input logic [9:0] ln, input logic odd);
    run_line(ln, odd);
    finish_line();
    chk({31'h0, seen_act}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge MCLK_I);
    SYS_RST_I   <= 1'b0;
    PIX_VALID_I <= 1'b1;
    repeat (30) @(posedge MCLK_I);
    chk({31'h0, PIX_READY_O}, 32'h0);
    stall <= 1'b0;
    rd(OFS_CTRL, {24'h0, CTRL_RESET}, RESP_OKAY);
    rd(OFS_CC0, 32'h0, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(OFS_CTRL, 32'h07, RESP_OKAY);
    seed = xs(seed);
    cap_line(LINE_CC_ODD, 1'b1, OFS_CC0, OFS_CC1, seed[7:0], seed[15:8]);
    cap_line(LINE_CC_EVEN, 1'b0, OFS_CCX0, OFS_CCX1, seed[23:16], seed[31:24]);
    cap_line(LINE_CC_ODD, 1'b1, OFS_CC0, OFS_CC1, 8'h00, 8'h00);
    seed = xs(seed);
    cg_line(LINE_CGMS_ODD, 1'b1, {4'h3, seed[3:0]}, seed[15:8], seed[23:16]);
    cg_line(LINE_CGMS_ODD, 1'b1, 8'h30, 8'hC0, 8'h00);
    cg_line(LINE_CGMS_EVEN, 1'b0, {4'h4, seed[7:4]}, seed[31:24], seed[23:16]);
    quiet(LINE_CGMS_ODD, 1'b1);
    wr(OFS_CGMS0, 32'h30, RESP_OKAY);
    wr(OFS_CTRL, 32'h00, RESP_OKAY);
    quiet(LINE_CGMS_ODD, 1'b1);
    rd(OFS_STATUS, 32'h0003_0308, RESP_OKAY);
    PIX_VALID_I <= 1'b0;
    repeat (40) @(posedge MCLK_I);
    chk({31'h0, VID_VALID_O}, 32'h0);
    test_done();
  end
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule // tb_top

//--- verification/vci_sink.sv
// Purpose: Video sink model at the far side of the inserter output.
// Assumes: A sample moves when valid and ready are both high.
// Notes:   Ready follows an LFSR so stalls are irregular; stall_i blocks it fully.
`timescale 1ns/1ps
module vci_sink (
  input  wire logic clk_i,   // Clock.
  input  wire logic rst_i,   // Async reset, active high.
  input  wire logic stall_i, // Hold ready low.
  output logic      ready_o  // Sample accepted.
);
  logic [7:0] lfsr_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lfsr_reg <= 8'h5A;
      ready_o  <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      ready_o  <= !stall_i && (lfsr_reg[1:0] != 2'h0);
    end
  end
endmodule // vci_sink
